/* rtl/pcc_pkg.sv */
package pcc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int PCC_ADDR_W = 12;
   localparam logic [PCC_ADDR_W-1:0] PCC_CTRL_OFF = 12'h000;
   localparam logic [PCC_ADDR_W-1:0] PCC_STAT_OFF = 12'h010;
   localparam logic [31:0] PCC_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] PCC_ZERO_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------
   // control field positions
   // ----------------------------------------------------------------
   localparam int PCC_MODE_LSB = 0;
   localparam int PCC_MODE_MSB = 1;
   localparam int PCC_DIR_BIT = 2;
   localparam int PCC_FALL_BIT = 3;
   localparam int PCC_PULSE_WIDTH_FILTER_ENABLE_BIT = 4;
   localparam int PCC_DOM_HOLD_BIT = 5;
   localparam int PCC_AUX_HOLD_BIT = 6;
   localparam int PCC_CTRL_W = 7;

   // ----------------------------------------------------------------
   // status field positions
   // ----------------------------------------------------------------
   localparam int PCC_STAT_DIR_BIT = 0;
   localparam int PCC_STAT_DOM_BIT = 1;
   localparam int PCC_STAT_AUX_BIT = 2;
   localparam int PCC_STAT_W = 3;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int PCC_FILTER_LEN = 5;
   localparam int PCC_SYNC_STAGES = 3;

   // operating mode encoding
   typedef enum logic [1:0] {
      PCC_MODE_DISABLED = 2'h0,
      PCC_MODE_OVS_SINGLE = 2'h1,
      PCC_MODE_EXT_SINGLE = 2'h2,
      PCC_MODE_EXT_QUAD = 2'h3
   } pcc_mode_t;

   // control register image, msb first so it maps bits 6:0
   typedef struct packed {
      logic aux_counter_reset_hold;
      logic count_domain_reset_hold;
      logic pulse_width_filter_enable;
      logic falling_polarity;
      logic count_direction;
      pcc_mode_t mode;
   } pcc_ctrl_t;

   // count events towards the counter
   typedef struct packed {
      logic up;
      logic down;
   } pcc_count_t;

endpackage

/* rtl/pcc_rst_sync.sv */
`timescale 1ns/10ps
module pcc_rst_sync (
   // counter-domain clock
   input wire logic clk,
   // asynchronous assert, low active
   input wire logic arst_n,
   // reset released two clock edges after arst_n rises
   output logic rst_n
);
   import pcc_pkg::*;

   logic [1:0] stage;
   logic [1:0] edges_since;

   // ----------------------------------------------------------------
   // two-stage release: assert at once, let go synchronously
   // ----------------------------------------------------------------
   // stage[0] only feeds stage[1], so a late release cannot go metastable
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage <= 2'b00;
      end else begin
         stage <= {stage[0], 1'b1}; // RULE_01 RULE_02
      end
   end

   assign rst_n = stage[1];

   // edge counter seen only by the check below
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         edges_since <= 2'b00;
      end else if (edges_since != 2'b11) begin
         edges_since <= edges_since + 2'b01;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_release_after_two: assert property ( // RULE_02
      @(posedge clk) disable iff (!arst_n)
      rst_n == (edges_since >= 2'b10))
      else $error("domain reset not released after two edges");

endmodule

/* rtl/pcc_top.sv */
// Contract
// [RULE_01] aux reset held; released two edges later
// [RULE_02] domain reset held; released two edges later
// [RULE_03] without clock, software toggles reset without waiting
// [RULE_04] filter passes periods of five samples
// [RULE_05] oversampled mode counts rising or falling edges
// [RULE_06] falling polarity inverts quadrature direction
// [RULE_07] change polarity only while disabled
// [RULE_08] single-input direction: 0 up, 1 down
// [RULE_09] quadrature ignores direction field
// [RULE_10] mode 0 disabled, 1 oversampled single
// [RULE_11] mode 2 externally clocked single input
// [RULE_12] mode 3 externally clocked quadrature
// [RULE_13] all control fields reset to zero
// [RULE_14] software routes counter clock before enabling
`timescale 1ns/10ps
module pcc_top #(
   parameter int FILTER_LEN = pcc_pkg::PCC_FILTER_LEN
) (
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pcc_pkg::PCC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // counter clock and count pins
   input wire logic count_clk,
   input wire logic primary_count_input,
   input wire logic secondary_count_input,
   // towards counter logic, count_clk domain
   output pcc_pkg::pcc_count_t count_event,
   output logic count_down_dir,
   output logic count_domain_rst_n,
   output logic aux_counter_rst_n
);
   import pcc_pkg::*;

   localparam int LINK_W = 7;
   localparam int PULSE_WIDTH_FILTER_ENABLE_CNT_W = 4;
   localparam logic [PULSE_WIDTH_FILTER_ENABLE_CNT_W-1:0] PULSE_WIDTH_FILTER_ENABLE_LAST = PULSE_WIDTH_FILTER_ENABLE_CNT_W'(FILTER_LEN - 1);

   // refused at elaboration: the run counter holds at most 15
   if (FILTER_LEN < 2 || FILTER_LEN > 15) begin : g_bad_filter_len
      $error("FILTER_LEN must be 2 to 15");
   end

   // ----------------------------------------------------------------
   // apb register file, pclk domain
   // ----------------------------------------------------------------
   pcc_ctrl_t ctrl;
   logic [PCC_STAT_W-1:0] stat_stable;
   logic access_done;
   logic hit_ctrl;
   logic hit_stat;

   assign access_done = psel && penable && pready;
   assign hit_ctrl = (paddr == PCC_CTRL_OFF);
   assign hit_stat = (paddr == PCC_STAT_OFF);

   // control register: every field starts at zero, unit disabled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= pcc_ctrl_t'(PCC_CTRL_RESET[PCC_CTRL_W-1:0]); // RULE_13
      end else if (access_done && pwrite && hit_ctrl) begin
         ctrl <= pcc_ctrl_t'(pwdata[PCC_CTRL_W-1:0]); // RULE_10
      end
   end

   // one wait state keeps prdata and pready straight from flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   // read data and error latched in the wait cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= PCC_ZERO_WORD;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pslverr <= !(hit_ctrl || hit_stat);
         if (pwrite) begin
            prdata <= PCC_ZERO_WORD;
         end else if (hit_ctrl) begin
            prdata <= {{(32-PCC_CTRL_W){1'b0}}, ctrl};
         end else if (hit_stat) begin
            prdata <= {{(32-PCC_STAT_W){1'b0}}, stat_stable};
         end else begin
            prdata <= PCC_ZERO_WORD;
         end
      end else begin
         pslverr <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // domain resets into count_clk
   // ----------------------------------------------------------------
   logic dom_arst_n;
   logic aux_arst_n;
   // set bit asserts at once; hold bit from a flop, so no glitch
   assign dom_arst_n = presetn && !ctrl.count_domain_reset_hold;
   // the aux counter also goes down with the whole domain
   assign aux_arst_n = dom_arst_n && !ctrl.aux_counter_reset_hold;
   pcc_rst_sync u_dom_rst (
      .clk(count_clk),
      .arst_n(dom_arst_n),
      .rst_n(count_domain_rst_n)
   ); // RULE_02
   pcc_rst_sync u_aux_rst (
      .clk(count_clk),
      .arst_n(aux_arst_n),
      .rst_n(aux_counter_rst_n)
   ); // RULE_01

   // ----------------------------------------------------------------
   // control and pins into count_clk
   // ----------------------------------------------------------------
   // quasi-static fields; software keeps them still while they
   // settle, polarity only while disabled
   logic [LINK_W-1:0] link_raw;
   logic [LINK_W-1:0] link_s1;
   logic [LINK_W-1:0] link_s2;
   logic [LINK_W-1:0] link_s3;
   logic [LINK_W-1:0] link_stable;

   assign link_raw = {secondary_count_input, primary_count_input,
                      ctrl.pulse_width_filter_enable,
                      ctrl.falling_polarity, ctrl.count_direction,
                      ctrl.mode};

   genvar gl;
   generate
      for (gl = 0; gl < LINK_W; gl++) begin : g_link_sync
         // a change counts once the second and third stages agree
         always_ff @(posedge count_clk or negedge count_domain_rst_n) begin
            if (!count_domain_rst_n) begin
               link_s1[gl] <= 1'b0;
               link_s2[gl] <= 1'b0;
               link_s3[gl] <= 1'b0;
               link_stable[gl] <= 1'b0;
            end else begin
               link_s1[gl] <= link_raw[gl];
               link_s2[gl] <= link_s1[gl];
               link_s3[gl] <= link_s2[gl];
               if (link_s2[gl] == link_s3[gl]) begin
                  link_stable[gl] <= link_s3[gl];
               end
            end
         end
      end
   endgenerate

   pcc_mode_t l_mode;
   logic l_dir;
   logic l_fall;
   logic l_pulse_width_filter_enable;
   logic l_in0;
   logic l_in1;

   assign l_mode = pcc_mode_t'(link_stable[1:0]);
   assign l_dir = link_stable[2];
   assign l_fall = link_stable[3];
   assign l_pulse_width_filter_enable = link_stable[4];
   assign l_in0 = link_stable[5];
   assign l_in1 = link_stable[6];

   // ----------------------------------------------------------------
   // pulse width filter, oversampled mode only
   // ----------------------------------------------------------------
   logic pulse_width_filter_enable_on;
   logic pulse_width_filter_enable_lvl;
   logic [PULSE_WIDTH_FILTER_ENABLE_CNT_W-1:0] pulse_width_filter_enable_run;

   assign pulse_width_filter_enable_on = l_pulse_width_filter_enable && (l_mode == PCC_MODE_OVS_SINGLE); // RULE_04

   // a new level must persist FILTER_LEN samples before it passes
   always_ff @(posedge count_clk or negedge count_domain_rst_n) begin
      if (!count_domain_rst_n) begin
         pulse_width_filter_enable_lvl <= 1'b0;
         pulse_width_filter_enable_run <= '0;
      end else if (!pulse_width_filter_enable_on || l_in0 == pulse_width_filter_enable_lvl) begin
         pulse_width_filter_enable_lvl <= pulse_width_filter_enable_on ? pulse_width_filter_enable_lvl : l_in0;
         pulse_width_filter_enable_run <= '0;
      end else if (pulse_width_filter_enable_run == PULSE_WIDTH_FILTER_ENABLE_LAST) begin
         pulse_width_filter_enable_lvl <= l_in0; // RULE_04
         pulse_width_filter_enable_run <= '0;
      end else begin
         pulse_width_filter_enable_run <= pulse_width_filter_enable_run + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // edge detect and count decision
   // ----------------------------------------------------------------
   logic ovs_prev;
   logic ovs_edge;
   logic next_up;
   logic next_down;
   logic next_dir;

   always_ff @(posedge count_clk or negedge count_domain_rst_n) begin
      if (!count_domain_rst_n) begin
         ovs_prev <= 1'b0;
      end else begin
         ovs_prev <= pulse_width_filter_enable_lvl;
      end
   end

   // polarity picks which transition of the input is counted
   assign ovs_edge = l_fall ? (ovs_prev && !pulse_width_filter_enable_lvl)
                            : (!ovs_prev && pulse_width_filter_enable_lvl); // RULE_05

   // in the external modes every count clock edge is one count
   always_comb begin
      next_up = 1'b0;
      next_down = 1'b0;
      next_dir = count_down_dir;
      case (l_mode)
         PCC_MODE_DISABLED: begin
            next_dir = 1'b0; // RULE_10
         end
         PCC_MODE_OVS_SINGLE: begin
            next_dir = l_dir; // RULE_08
            next_up = ovs_edge && !l_dir;
            next_down = ovs_edge && l_dir;
         end
         PCC_MODE_EXT_SINGLE: begin
            next_dir = l_dir; // RULE_11
            next_up = !l_dir;
            next_down = l_dir;
         end
         PCC_MODE_EXT_QUAD: begin
            // phase of the second input sets the way; field ignored
            next_dir = l_in1 ^ l_fall; // RULE_06 RULE_09 RULE_12
            next_up = !next_dir;
            next_down = next_dir;
         end
         default: begin
            next_dir = 1'b0;
         end
      endcase
   end

   // registered count strobes and direction
   always_ff @(posedge count_clk or negedge count_domain_rst_n) begin
      if (!count_domain_rst_n) begin
         count_event <= '0;
         count_down_dir <= 1'b0;
      end else begin
         count_event.up <= next_up;
         count_event.down <= next_down;
         count_down_dir <= next_dir;
      end
   end

   // ----------------------------------------------------------------
   // status back into pclk
   // ----------------------------------------------------------------
   logic [PCC_STAT_W-1:0] stat_raw;
   logic [PCC_STAT_W-1:0] stat_s1;
   logic [PCC_STAT_W-1:0] stat_s2;
   logic [PCC_STAT_W-1:0] stat_s3;

   assign stat_raw = {!aux_counter_rst_n, !count_domain_rst_n,
                      count_down_dir};

   genvar gs;
   generate
      for (gs = 0; gs < PCC_STAT_W; gs++) begin : g_stat_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stat_s1[gs] <= 1'b0;
               stat_s2[gs] <= 1'b0;
               stat_s3[gs] <= 1'b0;
               stat_stable[gs] <= 1'b0;
            end else begin
               stat_s1[gs] <= stat_raw[gs];
               stat_s2[gs] <= stat_s1[gs];
               stat_s3[gs] <= stat_s2[gs];
               if (stat_s2[gs] == stat_s3[gs]) begin
                  stat_stable[gs] <= stat_s3[gs];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_ctrl_write_lands: assert property ( // RULE_10
      @(posedge pclk) disable iff (!presetn)
      access_done && pwrite && hit_ctrl
      |=> ctrl == $past(pwdata[PCC_CTRL_W-1:0]))
      else $error("control write not stored");
   a_one_wait_state: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer timing wrong");
   a_unmapped_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pready && !hit_ctrl && !hit_stat
      |=> pready && pslverr)
      else $error("unmapped access not flagged");
   a_hold_asserts_reset: assert property ( // RULE_01
      @(posedge pclk) disable iff (!presetn)
      ctrl.aux_counter_reset_hold |-> !aux_counter_rst_n)
      else $error("aux counter not held in reset");
   a_ovs_count_dir: assert property ( // RULE_08
      @(posedge count_clk) disable iff (!count_domain_rst_n)
      l_mode == PCC_MODE_OVS_SINGLE && ovs_edge
      |=> (count_event.down == $past(l_dir))
          && (count_event.up == !$past(l_dir)))
      else $error("oversampled count direction wrong");
   a_ovs_polarity: assert property ( // RULE_05
      @(posedge count_clk) disable iff (!count_domain_rst_n)
      l_mode == PCC_MODE_OVS_SINGLE && !l_fall
      && ovs_prev && !pulse_width_filter_enable_lvl
      |=> !count_event.up && !count_event.down)
      else $error("falling edge counted with rising polarity");
   a_quad_direction: assert property ( // RULE_06
      @(posedge count_clk) disable iff (!count_domain_rst_n)
      l_mode == PCC_MODE_EXT_QUAD
      |=> count_down_dir == $past(l_in1 ^ l_fall)
          && count_event.down == count_down_dir)
      else $error("quadrature direction wrong");
   a_disabled_silent: assert property ( // RULE_10
      @(posedge count_clk) disable iff (!count_domain_rst_n)
      l_mode == PCC_MODE_DISABLED
      |=> !count_event.up && !count_event.down)
      else $error("count while disabled");
   a_ext_single_count: assert property ( // RULE_11
      @(posedge count_clk) disable iff (!count_domain_rst_n)
      l_mode == PCC_MODE_EXT_SINGLE
      |=> count_event.up ^ count_event.down)
      else $error("external single mode missed an edge");
   a_filter_min_width: assert property ( // RULE_04
      @(posedge count_clk) disable iff (!count_domain_rst_n)
      $past(pulse_width_filter_enable_on) && pulse_width_filter_enable_on && $changed(pulse_width_filter_enable_lvl)
      |-> $past(l_in0, 1) == pulse_width_filter_enable_lvl && $past(l_in0, 2) == pulse_width_filter_enable_lvl
          && $past(l_in0, 3) == pulse_width_filter_enable_lvl
          && $past(l_in0, 4) == pulse_width_filter_enable_lvl
          && $past(l_in0, 5) == pulse_width_filter_enable_lvl)
      else $error("filter passed a short period");
   c_ovs_count: cover property (
      @(posedge count_clk) disable iff (!count_domain_rst_n)
      l_mode == PCC_MODE_OVS_SINGLE && count_event.up);
   c_quad_down: cover property (
      @(posedge count_clk) disable iff (!count_domain_rst_n)
      l_mode == PCC_MODE_EXT_QUAD && count_event.down);
   c_filter_pass: cover property (
      @(posedge count_clk) disable iff (!count_domain_rst_n)
      pulse_width_filter_enable_on && $changed(pulse_width_filter_enable_lvl));
   c_dom_reset: cover property (
      @(posedge pclk) disable iff (!presetn)
      $fell(ctrl.count_domain_reset_hold));
endmodule

/* tb/pcc_pulse_source.sv */
`timescale 1ns/10ps
module pcc_pulse_source (
   // commands from the bench
   input wire logic run,
   input wire logic pri_lvl,
   input wire logic sec_lvl,
   // towards the block
   output logic count_clk,
   output logic primary_count_input,
   output logic secondary_count_input
);
   // ----------------------------------------------------------------
   // source clock
   // ----------------------------------------------------------------
   // an external source stops between bursts; it only halts low so that
   // no half period is ever cut short; one process owns clock and pins
   initial begin
      count_clk = 1'b0;
      primary_count_input = 1'b0;
      secondary_count_input = 1'b0;
      #37;
      forever begin
         if (run || count_clk) begin
            #80;
            count_clk = ~count_clk;
            // pins move on the falling edge, clear of sampling
            if (!count_clk) begin
               primary_count_input = pri_lvl;
               secondary_count_input = sec_lvl;
            end
         end else begin
            // restart off phase so no edge meets a pclk edge
            @(posedge run);
            #37;
         end
      end
   end
endmodule

/* tb/pulse_counter_control_tb.sv */
`timescale 1ns/10ps
module pulse_counter_control_tb;
   import pcc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [PCC_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic count_clk, primary_count_input, secondary_count_input;
   logic run, pri_lvl, sec_lvl, count_down_dir;
   logic count_domain_rst_n, aux_counter_rst_n;
   pcc_count_t count_event;
   int fails, checks;
   int ups = 0;
   int dns = 0;
   logic [31:0] ovs [0:5] = '{32'h0000_0001, 32'h0000_0005, 32'h0000_0009,
      32'h0000_000D, 32'h0000_0000, 32'h0000_0011};
   logic [31:0] ev [0:5] = '{32'h0000_0012, 32'h0000_0006, 32'h0000_0007,
      32'h0000_0003, 32'h0000_000B, 32'h0000_000F};
   logic es [0:5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   logic ed [0:5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

   // ----------------------------------------------------------------
   // clock, design and source
   // ----------------------------------------------------------------
   always #50 pclk = ~pclk;
   pcc_top #(.FILTER_LEN(PCC_FILTER_LEN)) pcc_top_inst (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_clk(count_clk),
      .primary_count_input(primary_count_input),
      .secondary_count_input(secondary_count_input),
      .count_event(count_event), .count_down_dir(count_down_dir),
      .count_domain_rst_n(count_domain_rst_n),
      .aux_counter_rst_n(aux_counter_rst_n));
   pcc_pulse_source pcc_pulse_source_inst (.run(run), .pri_lvl(pri_lvl),
      .sec_lvl(sec_lvl), .count_clk(count_clk),
      .primary_count_input(primary_count_input),
      .secondary_count_input(secondary_count_input));

   // event tally, taken mid-cycle where the one-cycle pulses are settled
   always @(negedge count_clk) begin
      if (count_event.up === 1'b1) ups++;
      if (count_event.down === 1'b1) dns++;
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cmp32(input logic [31:0] g, input logic [31:0] e,
      input string m);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic cmp1(input logic g, input logic e, input string m);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: %s got %b exp %b", $time, m, g, e);
      end
   endtask
   // one apb transfer; right after a rising edge pready, prdata and
   // pslverr still hold what that edge sampled, so the answer is taken
   // at the edge that sees pready high, and only then released
   task automatic bus(input logic w, input logic [PCC_ADDR_W-1:0] a,
      input logic [31:0] d, input logic [31:0] x, input logic xe);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         final_report();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // let the edge's register updates land before callers look
      #1;
      cmp1(er, xe, "slave error");
      if (!w) cmp32(rd, x, "read data");
   endtask
   // polarity only ever changes from the disabled mode
   task automatic cfg(input logic [31:0] v);
      bus(1'b1, PCC_CTRL_OFF, PCC_ZERO_WORD, PCC_ZERO_WORD, 1'b0);
      bus(1'b1, PCC_CTRL_OFF, v, PCC_ZERO_WORD, 1'b0);
   endtask
   task automatic cc(input int n);
      repeat (n) @(posedge count_clk);
      #1;
   endtask
   task automatic pin(input logic v, input int n);
      pri_lvl <= v;
      cc(n);
   endtask

   // ----------------------------------------------------------------
   // hang guard and main sequence
   // ----------------------------------------------------------------
   initial begin
      #5000000;
      fails++;
      final_report();
   end
   initial begin
      int i, u, d;
      logic on;
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, run, pri_lvl, sec_lvl} = 6'h00;
      paddr = '0;
      pwdata = '0;
      fails = 0;
      checks = 0;
      run = 1'b1;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      cc(4);
      cmp1(count_domain_rst_n, 1'b1, "domain reset free");
      cmp1(aux_counter_rst_n, 1'b1, "aux reset free");
      cmp1(count_down_dir, 1'b0, "direction at reset");
      bus(1'b0, PCC_CTRL_OFF, '0, PCC_CTRL_RESET, 1'b0);
      bus(1'b0, PCC_STAT_OFF, '0, PCC_ZERO_WORD, 1'b0);
      // unmapped places refuse, status ignores writes, upper bits read 0
      bus(1'b0, 12'h008, '0, PCC_ZERO_WORD, 1'b1);
      bus(1'b1, 12'h004, 32'h0000_0013, '0, 1'b1);
      bus(1'b0, PCC_CTRL_OFF, '0, PCC_CTRL_RESET, 1'b0);
      bus(1'b1, PCC_STAT_OFF, 32'hFFFF_FFFF, '0, 1'b0);
      bus(1'b0, PCC_STAT_OFF, '0, PCC_ZERO_WORD, 1'b0);
      bus(1'b1, PCC_CTRL_OFF, 32'hFFFF_FF9C, '0, 1'b0);
      bus(1'b0, PCC_CTRL_OFF, '0, 32'h0000_001C, 1'b0);
      // hold bits with the source clock running: domain, then aux
      for (i = 0; i < 2; i++) begin
         bus(1'b1, PCC_CTRL_OFF, i ? 32'h0000_0040 : 32'h0000_0020, '0, 0);
         cmp1(aux_counter_rst_n, 1'b0, "aux held");
         cmp1(count_domain_rst_n, i[0], "domain held");
         repeat (4) @(posedge pclk);
         bus(1'b0, PCC_STAT_OFF, '0, i ? 32'h4 : 32'h6, 1'b0);
         bus(1'b1, PCC_CTRL_OFF, PCC_ZERO_WORD, '0, 1'b0);
         cc(1);
         cmp1(aux_counter_rst_n, 1'b0, "aux still held");
         cmp1(count_domain_rst_n, i[0], "domain still held");
         cc(2);
         cmp1(aux_counter_rst_n, 1'b1, "aux released");
         cmp1(count_domain_rst_n, 1'b1, "domain released");
      end
      // with the source stopped, set and clear without waiting
      run <= 1'b0;
      repeat (10) @(posedge pclk);
      bus(1'b1, PCC_CTRL_OFF, 32'h0000_0060, '0, 1'b0);
      bus(1'b1, PCC_CTRL_OFF, PCC_ZERO_WORD, '0, 1'b0);
      cmp1(count_domain_rst_n, 1'b0, "domain held unclocked");
      cmp1(aux_counter_rst_n, 1'b0, "aux held unclocked");
      run <= 1'b1;
      cc(3);
      cmp1(count_domain_rst_n, 1'b1, "domain freed");
      cmp1(aux_counter_rst_n, 1'b1, "aux freed");
      // oversampled single input: polarity, direction, disabled, filter
      for (i = 0; i < 6; i++) begin
         on = (ovs[i][1:0] != 2'h0);
         cfg(ovs[i]);
         cc(8);
         u = ups;
         d = dns;
         pin(1'b1, 12);
         cmp32(ups + dns - u - d, 32'(on && !ovs[i][3]), "rise");
         pin(1'b0, 12);
         cmp32(ups - u, 32'(on && !ovs[i][2]), "up count");
         cmp32(dns - d, 32'(on && ovs[i][2]), "down count");
      end
      // filter boundary: one sample short is swallowed, exact length passes
      u = ups;
      pin(1'b1, PCC_FILTER_LEN - 1);
      pin(1'b0, 12);
      cmp32(ups - u, 32'h0, "short pulse");
      pin(1'b1, PCC_FILTER_LEN);
      pin(1'b0, 12);
      cmp32(ups - u, 32'h1, "long pulse");
      // externally clocked modes count every source edge
      for (i = 0; i < 6; i++) begin
         sec_lvl <= es[i];
         cfg(ev[i]);
         cc(8);
         u = ups;
         d = dns;
         cc(16);
         cmp32(ups - u, ed[i] ? 32'd0 : 32'd16, "ext up");
         cmp32(dns - d, ed[i] ? 32'd16 : 32'd0, "ext down");
         cmp1(count_down_dir, ed[i], "ext direction");
         bus(1'b0, PCC_STAT_OFF, '0, 32'(ed[i]), 1'b0);
      end
      cfg(PCC_ZERO_WORD);
      final_report();
   end
endmodule
